// File: hw/dpr_params.svh
`ifndef DPR_PARAMS_SVH
`define DPR_PARAMS_SVH
// ==========================================
// Register offsets (byte addresses)
`define DPR_OFF_CTRL    12'h000
`define DPR_OFF_ADDR    12'h004
`define DPR_OFF_WDATA   12'h008
`define DPR_OFF_RDATA   12'h00C
`define DPR_OFF_STATUS  12'h010
// ==========================================
// Control fields
`define DPR_CTRL_GO     0
`define DPR_CTRL_WRITE  1
`define DPR_CTRL_UPPER  2
`define DPR_CTRL_LOWER  3
`define DPR_CTRL_TOKEN  4
`define DPR_CTRL_RESET  32'h0000_0000
// Status fields
`define DPR_ST_BUSY     0
`define DPR_ST_CONT     1
`define DPR_ST_MAIL     2
`define DPR_ST_DONE     3
// ==========================================
// Timing: 100 ns clock period
`define DPR_CLK_NS      100
`define DPR_STROBE_NS   15
`define DPR_STROBE_CYC  (((`DPR_STROBE_NS) + (`DPR_CLK_NS) - 1) / (`DPR_CLK_NS))
`define DPR_FLOW_NS     45
`define DPR_FLOW_CYC    (((`DPR_FLOW_NS) + (`DPR_CLK_NS) - 1) / (`DPR_CLK_NS))
`define DPR_TOKEN_MASK  16'h0007
`endif

// File: hw/dpr_pkg.sv
package dpr_pkg;
   typedef struct packed {
      logic [15:0] addr;
      logic        sel_n;
      logic        tok_n;
      logic        we_n;
      logic        oe_n;
      logic        upper_lane_en_n;
      logic        lower_lane_en_n;
   } dpr_pins_s;
   typedef struct packed {
      logic [15:0] dout;
      logic [15:0] doe;
   } dpr_data_s;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SETUP = 3'b001,
      ST_STRB  = 3'b010,
      ST_HOLD  = 3'b011,
      ST_WAIT  = 3'b100
   } dpr_state_e;
endpackage

// File: hw/dpr_axil.sv
`timescale 1ns/1ns
`include "dpr_params.svh"
module dpr_axil (
   input  wire logic        clk,      // Clock
   input  wire logic        rstn,     // Reset
   input  wire logic [11:0] awaddr,   // Write address
   input  wire logic        awvalid,  // Address valid
   output logic             awready,  // Address ready
   input  wire logic [31:0] wdata,    // Write data
   input  wire logic [3:0]  wstrb,    // Byte strobes
   input  wire logic        wvalid,   // Data valid
   output logic             wready,   // Data ready
   output logic [1:0]       bresp,    // Write response
   output logic             bvalid,   // Response valid
   input  wire logic        bready,   // Response ready
   input  wire logic [11:0] araddr,   // Read address
   input  wire logic        arvalid,  // Address valid
   output logic             arready,  // Address ready
   output logic [31:0]      rdata,    // Read data
   output logic [1:0]       rresp,    // Read response
   output logic             rvalid,   // Read valid
   input  wire logic        rready,   // Read ready
   output logic             wr_en,    // One-cycle register write
   output logic [11:0]      wr_addr,  // Write offset
   output logic [31:0]      wr_data,  // Write value
   output logic [3:0]       wr_strb,  // Write strobes
   output logic [11:0]      rd_addr,  // Read offset
   input  wire logic [31:0] rd_data,  // Read value
   input  wire logic        rd_ok     // Offset mapped
);
   logic aw_q, aw_d, w_q, w_d, b_d, r_d, wr_en_d;
   logic [11:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rdat_d;
   logic [3:0]  ws_q, ws_d;
   logic [1:0]  rresp_d;
   // ==========================================
   // Both halves of a write latch independently, then commit once
   always_comb begin
      aw_d    = aw_q;
      w_d     = w_q;
      awa_d   = awa_q;
      wd_d    = wd_q;
      ws_d    = ws_q;
      b_d     = bvalid;
      wr_en_d = 1'b0;
      if (awvalid && awready) begin
         aw_d  = 1'b1;
         awa_d = awaddr;
      end
      if (wvalid && wready) begin
         w_d  = 1'b1;
         wd_d = wdata;
         ws_d = wstrb;
      end
      if (aw_q && w_q && !bvalid) begin
         wr_en_d = 1'b1;
         aw_d    = 1'b0;
         w_d     = 1'b0;
         b_d     = 1'b1;
      end
      if (bvalid && bready) b_d = 1'b0;
      r_d     = rvalid;
      rdat_d  = rdata;
      rresp_d = rresp;
      if (arvalid && arready) begin
         r_d     = 1'b1;
         rdat_d  = rd_ok ? rd_data : 32'h0000_0000;
         rresp_d = rd_ok ? 2'h0 : 2'h2;
      end else if (rvalid && rready) begin
         r_d = 1'b0;
      end
   end
   assign awready = !aw_q && !bvalid;
   assign wready  = !w_q && !bvalid;
   assign arready = !rvalid;
   assign rd_addr = araddr;
   assign bresp   = 2'h0;
   assign wr_addr = awa_q;
   assign wr_data = wd_q;
   assign wr_strb = ws_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         aw_q   <= 1'b0;
         w_q    <= 1'b0;
         awa_q  <= 12'h000;
         wd_q   <= 32'h0000_0000;
         ws_q   <= 4'h0;
         bvalid <= 1'b0;
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= 2'h0;
         wr_en  <= 1'b0;
      end else begin
         aw_q   <= aw_d;
         w_q    <= w_d;
         awa_q  <= awa_d;
         wd_q   <= wd_d;
         ws_q   <= ws_d;
         bvalid <= b_d;
         rvalid <= r_d;
         rdata  <= rdat_d;
         rresp  <= rresp_d;
         wr_en  <= wr_en_d;
      end
   end
endmodule

// File: hw/dpr_host.sv
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "dpr_params.svh"
// What this block does
// - Host keeps write strobe high when reading
// - Write strobe high across every address change
// - Host drives data only once device released
// - Token access: no memory select; bit 0
module dpr_host
   import dpr_pkg::*;
(
   input  wire logic        CLOCK,     // 10 MHz clock
   input  wire logic        RSTN,      // Async reset, active low
   input  wire logic [11:0] AWADDR,    // AXI write address
   input  wire logic        AWVALID,   // AXI
   output logic             AWREADY,   // AXI
   input  wire logic [31:0] WDATA,     // AXI
   input  wire logic [3:0]  WSTRB,     // AXI
   input  wire logic        WVALID,    // AXI
   output logic             WREADY,    // AXI
   output logic [1:0]       BRESP,     // AXI
   output logic             BVALID,    // AXI
   input  wire logic        BREADY,    // AXI
   input  wire logic [11:0] ARADDR,    // AXI read address
   input  wire logic        ARVALID,   // AXI
   output logic             ARREADY,   // AXI
   output logic [31:0]      RDATA,     // AXI
   output logic [1:0]       RRESP,     // AXI
   output logic             RVALID,    // AXI
   input  wire logic        RREADY,    // AXI
   output dpr_pkg::dpr_pins_s PORT,    // Port control pins
   output logic [15:0]      DQ_O,      // Data out to device
   output logic             DQ_OE,     // High while host drives data
   input  wire logic [15:0] DQ_I,      // Data from device
   input  wire logic        CONT_N,    // contention_flag_n from device
   input  wire logic        MAIL_N     // mailbox_flag_n from device
);
   import dpr_pkg::*;
   logic        wr_en, rd_ok;
   logic [11:0] wr_addr, rd_addr;
   logic [31:0] wr_data, rd_data;
   logic [3:0]  wr_strb;
   dpr_state_e  st_q, st_d;
   dpr_pins_s   pins_q, pins_d;
   logic [15:0] dq_q, dq_d, rdat_q, rdat_d, addr_q, addr_d, wd_q, wd_d;
   logic        oe_q, oe_d, done_q, done_d, cont_q, cont_d;
   logic [4:0]  ctl_q, ctl_d;
   logic [3:0]  cnt_q, cnt_d;
   dpr_axil u_bus (
      .clk     (CLOCK),
      .rstn    (RSTN),
      .awaddr  (AWADDR),
      .awvalid (AWVALID),
      .awready (AWREADY),
      .wdata   (WDATA),
      .wstrb   (WSTRB),
      .wvalid  (WVALID),
      .wready  (WREADY),
      .bresp   (BRESP),
      .bvalid  (BVALID),
      .bready  (BREADY),
      .araddr  (ARADDR),
      .arvalid (ARVALID),
      .arready (ARREADY),
      .rdata   (RDATA),
      .rresp   (RRESP),
      .rvalid  (RVALID),
      .rready  (RREADY),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_strb (wr_strb),
      .rd_addr (rd_addr),
      .rd_data (rd_data),
      .rd_ok   (rd_ok)
   );
   // ==========================================
   // Register read mux
   always_comb begin
      rd_ok   = 1'b1;
      rd_data = 32'h0000_0000;
      unique case (rd_addr)
         `DPR_OFF_CTRL:   rd_data = {27'h0, ctl_q};
         `DPR_OFF_ADDR:   rd_data = {16'h0, addr_q};
         `DPR_OFF_WDATA:  rd_data = {16'h0, wd_q};
         `DPR_OFF_RDATA:  rd_data = {16'h0, rdat_q};
         `DPR_OFF_STATUS: rd_data = {28'h0, done_q, !MAIL_N, cont_q, st_q != ST_IDLE};
         default:         rd_ok = 1'b0;
      endcase
   end
   // ==========================================
   // Pin sequencer: one access per GO
   localparam logic [3:0] STRB_N = 4'(`DPR_STROBE_CYC);
   localparam logic [3:0] FLOW_N = 4'(`DPR_FLOW_CYC);
   always_comb begin
      st_d   = st_q;
      pins_d = pins_q;
      dq_d   = dq_q;
      oe_d   = oe_q;
      rdat_d = rdat_q;
      ctl_d  = ctl_q;
      addr_d = addr_q;
      wd_d   = wd_q;
      done_d = done_q;
      cont_d = cont_q;
      cnt_d  = cnt_q;
      if (st_q == ST_IDLE && wr_en && wr_strb[0]) begin
         unique case (wr_addr)
            `DPR_OFF_CTRL:  ctl_d  = wr_data[4:0];
            `DPR_OFF_ADDR:  addr_d = wr_data[15:0];
            `DPR_OFF_WDATA: wd_d   = wr_data[15:0];
            default: ;
         endcase
      end
      unique case (st_q)
         ST_IDLE: begin
            if (ctl_q[`DPR_CTRL_GO]) begin
               // Address settles while strobe and selects are high
               pins_d.we_n = 1'b1;
               pins_d.addr = ctl_q[`DPR_CTRL_TOKEN] ? (addr_q & `DPR_TOKEN_MASK) : addr_q;
               pins_d.upper_lane_en_n = ctl_q[`DPR_CTRL_TOKEN] | !ctl_q[`DPR_CTRL_UPPER];
               pins_d.lower_lane_en_n = ctl_q[`DPR_CTRL_TOKEN] | !ctl_q[`DPR_CTRL_LOWER];
               done_d = 1'b0;
               cont_d = 1'b0;
               st_d   = ST_SETUP;
            end
         end
         ST_SETUP: begin
            // Token access keeps memory select high, never both low
            pins_d.sel_n = ctl_q[`DPR_CTRL_TOKEN];
            pins_d.tok_n = !ctl_q[`DPR_CTRL_TOKEN];
            if (ctl_q[`DPR_CTRL_WRITE]) begin
               // Output enable high so the device never fights our drive
               pins_d.oe_n = 1'b1;
               pins_d.we_n = 1'b0;
               dq_d = ctl_q[`DPR_CTRL_TOKEN] ? {15'h0, wd_q[0]} : wd_q;
               oe_d = 1'b1;
            end else begin
               pins_d.oe_n = 1'b0;
            end
            cnt_d = STRB_N;
            st_d  = ST_STRB;
         end
         ST_STRB: begin
            if (!CONT_N) cont_d = 1'b1;
            if (cnt_q > 4'h1) begin
               cnt_d = cnt_q - 4'h1;
            end else begin
               // Strobe rises first; data and address still held
               pins_d.we_n  = 1'b1;
               pins_d.oe_n  = 1'b1;
               rdat_d = DQ_I;
               cnt_d  = FLOW_N;
               st_d   = ST_HOLD;
            end
         end
         ST_HOLD: begin
            pins_d.sel_n = 1'b1;
            pins_d.tok_n = 1'b1;
            oe_d = 1'b0;
            st_d = ST_WAIT;
         end
         ST_WAIT: begin
            // Spacing lets flowthrough and mailbox flags settle
            if (cnt_q > 4'h1) begin
               cnt_d = cnt_q - 4'h1;
            end else begin
               pins_d.upper_lane_en_n = 1'b1;
               pins_d.lower_lane_en_n = 1'b1;
               ctl_d[`DPR_CTRL_GO] = 1'b0;
               done_d = 1'b1;
               st_d   = ST_IDLE;
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         st_q   <= ST_IDLE;
         pins_q <= '{addr: 16'h0000, default: 1'b1};
         dq_q   <= 16'h0000;
         oe_q   <= 1'b0;
         rdat_q <= 16'h0000;
         ctl_q  <= 5'h00;
         addr_q <= 16'h0000;
         wd_q   <= 16'h0000;
         done_q <= 1'b0;
         cont_q <= 1'b0;
         cnt_q  <= 4'h0;
      end else begin
         st_q   <= st_d;
         pins_q <= pins_d;
         dq_q   <= dq_d;
         oe_q   <= oe_d;
         rdat_q <= rdat_d;
         ctl_q  <= ctl_d;
         addr_q <= addr_d;
         wd_q   <= wd_d;
         done_q <= done_d;
         cont_q <= cont_d;
         cnt_q  <= cnt_d;
      end
   end
   assign PORT  = pins_q;
   assign DQ_O  = dq_q;
   assign DQ_OE = oe_q;
endmodule

// File: tb/dpr_host_properties.sv
`timescale 1ns/1ns
module dpr_host_properties
   import dpr_pkg::*;
(
   input wire logic               CLOCK,  // Clock
   input wire logic               RSTN,   // Reset, active low
   input wire dpr_pkg::dpr_pins_s PORT,   // Port pins
   input wire logic [15:0]        DQ_O,   // Host data
   input wire logic               DQ_OE   // Host drives data
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RSTN);
   // ==========================================
   // Pin discipline
   rd_strobe_a: assert property ((!PORT.sel_n && !PORT.oe_n) |-> PORT.we_n)
      else $error("strobe low during read");
   addr_quiet_a: assert property ($changed(PORT.addr) |-> PORT.we_n && $past(PORT.we_n))
      else $error("address moved under strobe");
   tok_excl_a: assert property (!PORT.tok_n |-> PORT.sel_n && PORT.upper_lane_en_n && PORT.lower_lane_en_n)
      else $error("token select with memory select");
   drive_ok_a: assert property (DQ_OE |-> PORT.oe_n)
      else $error("data driven against device");
   wr_overlap_a: assert property (
      !PORT.we_n |-> DQ_OE && (!PORT.tok_n ||
      (!PORT.sel_n && !(PORT.upper_lane_en_n && PORT.lower_lane_en_n))))
      else $error("strobe outside select and lane");
   strobe_data_a: assert property (
      $fell(PORT.we_n) |=> (DQ_OE && $stable(DQ_O)) throughout (##[0:3] $rose(PORT.we_n)))
      else $error("write data moved or strobe stuck");
   sel_release_a: assert property ($rose(PORT.sel_n) |-> PORT.we_n && $past(PORT.we_n))
      else $error("select ended write before strobe");
   idle_quiet_a: assert property ((PORT.sel_n && PORT.tok_n) |-> !DQ_OE && PORT.we_n)
      else $error("activity while deselected");
   oe_pulse_a: assert property ($fell(PORT.oe_n) |-> ##[1:4] $rose(PORT.oe_n))
      else $error("read enable stuck");
endmodule
bind dpr_host dpr_host_properties chk_u (.CLOCK(CLOCK), .RSTN(RSTN), .PORT(PORT), .DQ_O(DQ_O), .DQ_OE(DQ_OE));

// File: tb/dpr_ram_model.sv
`timescale 1ns/1ns
module dpr_ram_model
   import dpr_pkg::*;
#(
   parameter logic [15:0] MBOX = 16'hFFFE
)(
   input wire logic               clk,       // Bench clock, float pattern only
   input wire dpr_pkg::dpr_pins_s pins,      // Host control pins
   input wire logic [15:0]        dq_o,      // Host data
   input wire logic               dq_oe,     // Host drives data
   output logic [15:0]            dq_i,      // Data towards host
   output logic                   cont_n,    // Contention flag
   output logic                   mail_n,    // Mailbox flag
   input wire logic               cont_req,  // Far port collides
   input wire logic               rt_mail,   // Far port writes our mailbox
   input wire logic [7:0]         tok_right  // Latches held by far port
);
   logic [15:0] mem [0:65535];
   logic [7:0]  own_l;
   logic        mail_l;
   logic [15:0] junk;
   wire         we_n = pins.we_n;
   wire         oe_n = pins.oe_n;
   initial begin
      own_l = 8'h00;
      mail_l = 1'b0;
      junk = 16'hA5C3;
   end
   // Floating lanes change value on every clock, so a stale read cannot pass
   always @(posedge clk) junk <= {junk[14:0], junk[15] ^ junk[13]};
   // Slave role: the flag is the master's verdict, so only this side ever sees it low
   assign cont_n = !cont_req;
   assign mail_n = !mail_l;
   always @(posedge rt_mail) mail_l = 1'b1;
   always @(negedge oe_n) begin
      if (!pins.sel_n && pins.tok_n && pins.addr == MBOX && cont_n) mail_l = 1'b0;
   end
   always @(posedge we_n) begin
      if (!pins.tok_n && pins.sel_n) begin
         if (dq_o[0]) own_l[pins.addr[2:0]] = 1'b0;
         else if (!tok_right[pins.addr[2:0]]) own_l[pins.addr[2:0]] = 1'b1;
      end else if (!pins.sel_n && cont_n) begin
         if (!pins.upper_lane_en_n) mem[pins.addr][15:8] = dq_oe ? dq_o[15:8] : junk[15:8];
         if (!pins.lower_lane_en_n) mem[pins.addr][7:0] = dq_oe ? dq_o[7:0] : junk[7:0];
      end
   end
   always @* begin
      dq_i = junk;
      if (!oe_n && we_n && !pins.tok_n && pins.sel_n) dq_i = {16{!own_l[pins.addr[2:0]]}};
      else if (!oe_n && we_n && !pins.sel_n) begin
         if (!pins.upper_lane_en_n) dq_i[15:8] = mem[pins.addr][15:8];
         if (!pins.lower_lane_en_n) dq_i[7:0] = mem[pins.addr][7:0];
      end
   end
endmodule

// File: tb/dpr_host_tb_top.sv
`timescale 1ns/1ns
`include "dpr_params.svh"
module dpr_host_tb_top;
   import dpr_pkg::*;
   logic        CLOCK, RSTN, AWVALID, WVALID, BREADY, ARVALID, RREADY, cont_req, rt_mail;
   logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, DQ_OE, CONT_N, MAIL_N;
   logic [11:0] AWADDR, ARADDR;
   logic [31:0] WDATA, RDATA, v;
   logic [3:0]  WSTRB;
   logic [1:0]  BRESP, RRESP;
   logic [15:0] DQ_O, DQ_I, a, d, e;
   logic [7:0]  tok_right;
   logic [65:0] ent;
   dpr_pins_s   PORT;
   logic [65:0] expq[$];
   string       nmq[$];
   string       nm;
   int          errors, n_checks, cyc, i;
   logic [4:0]  lw [3] = '{5'h06, 5'h0A, 5'h0E};
   logic [4:0]  lr [3] = '{5'h04, 5'h08, 5'h0C};
   logic [15:0] lm [3] = '{16'hFF00, 16'h00FF, 16'hFFFF};
   logic [15:0] ta [3] = '{16'h1233, 16'h0005, 16'h0003};
   logic [15:0] td [3] = '{16'h0000, 16'h0000, 16'h0001};
   logic [15:0] te [3] = '{16'h0000, 16'hFFFF, 16'hFFFF};
   dpr_host dut_u (.CLOCK(CLOCK), .RSTN(RSTN), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
      .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
      .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
      .RVALID(RVALID), .RREADY(RREADY), .PORT(PORT), .DQ_O(DQ_O), .DQ_OE(DQ_OE), .DQ_I(DQ_I),
      .CONT_N(CONT_N), .MAIL_N(MAIL_N));
   dpr_ram_model mdl_u (.clk(CLOCK), .pins(PORT), .dq_o(DQ_O), .dq_oe(DQ_OE), .dq_i(DQ_I), .cont_n(CONT_N),
      .mail_n(MAIL_N), .cont_req(cont_req), .rt_mail(rt_mail), .tok_right(tok_right));
   // ==========================================
   // Checking and closing
   task automatic chk(input string n, input logic [33:0] x, input logic [33:0] g);
      n_checks++;
      if (g !== x) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge CLOCK) begin
      cyc <= cyc + 1;
      if (RVALID && RREADY && expq.size() > 0) begin
         ent = expq.pop_front();
         nm = nmq.pop_front();
         if (ent[65:34] != 32'h0) chk(nm, {ent[33:32], ent[31:0] & ent[65:34]}, {RRESP, RDATA & ent[65:34]});
      end
      if (cyc == 6000) begin
         errors++;
         summarize();
      end
   end
   // ==========================================
   // Bus and sequencer tasks
   task automatic axw(input logic [11:0] ad, input logic [31:0] dt);
      int t;
      t = 0;
      @(posedge CLOCK);
      AWADDR <= ad;
      WDATA <= dt;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      do begin
         @(posedge CLOCK);
         t++;
         if (AWVALID && AWREADY) AWVALID <= 1'b0;
         if (WVALID && WREADY) WVALID <= 1'b0;
      end while (!(BVALID && BREADY) && t < 100);
      if (!(BVALID && BREADY)) begin
         errors++;
         $display("[ERR] bvalid expected 1 seen 0");
      end
      chk("bresp", 34'h0, {32'h0, BRESP});
      BREADY <= 1'b0;
   endtask
   task automatic axr(input logic [11:0] ad, input logic [31:0] x, input logic [31:0] m,
                      input logic [1:0] r, input string n, output logic [31:0] o);
      int t;
      t = 0;
      @(posedge CLOCK);
      expq.push_back({m, r, x});
      nmq.push_back(n);
      ARADDR <= ad;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do begin
         @(posedge CLOCK);
         t++;
         if (ARVALID && ARREADY) ARVALID <= 1'b0;
      end while (!(RVALID && RREADY) && t < 100);
      if (!(RVALID && RREADY)) begin
         errors++;
         $display("[ERR] rvalid expected 1 seen 0");
      end
      o = RDATA;
      RREADY <= 1'b0;
   endtask
   // Polls until the sequencer reports done, then checks busy is gone
   task automatic op(input logic [4:0] c, input logic [15:0] ad, input logic [15:0] dt);
      logic [31:0] s;
      int k;
      k = 0;
      axw(`DPR_OFF_ADDR, {16'h0000, ad});
      axw(`DPR_OFF_WDATA, {16'h0000, dt});
      axw(`DPR_OFF_CTRL, {27'h0000000, c} | 32'h00000001);
      do begin
         axr(`DPR_OFF_STATUS, 32'h0, 32'h0, 2'b00, "poll", s);
         k++;
      end while ((s[`DPR_ST_BUSY] || !s[`DPR_ST_DONE]) && k < 40);
      chk("op_done", 34'h8, {2'b00, s} & 34'h9);
   endtask
   // ==========================================
   // Main sequence
   initial begin
      CLOCK = 1'b0;
      forever #50 CLOCK = ~CLOCK;
   end
   initial begin
      {RSTN, AWVALID, WVALID, BREADY, ARVALID, RREADY, cont_req, rt_mail} = 8'h00;
      {AWADDR, ARADDR, WDATA, tok_right} = '0;
      WSTRB = 4'hF;
      errors = 0;
      n_checks = 0;
      void'($urandom(78151));
      repeat (16) @(posedge CLOCK);
      RSTN <= 1'b1;
      axr(`DPR_OFF_CTRL, `DPR_CTRL_RESET, 32'hFFFFFFFF, 2'b00, "ctrl_reset", v);
      axr(12'h020, 32'h0, 32'hFFFFFFFF, 2'b10, "unmapped", v);
      $display("test registers done");
      for (i = 0; i < 3; i++) begin
         a = 16'($urandom) & 16'h7FFF;
         d = 16'($urandom);
         e = (d & lm[i]) | (~d & ~lm[i]);
         op(5'h0E, a, ~d);
         op(lw[i], a, d);
         op(5'h0C, a, 16'h0000);
         axr(`DPR_OFF_RDATA, {16'h0000, e}, 32'h0000FFFF, 2'b00, "word", v);
         op(lr[i], a, 16'h0000);
         axr(`DPR_OFF_RDATA, {16'h0000, e}, {16'h0000, lm[i]}, 2'b00, "lane", v);
      end
      $display("test lanes done");
      tok_right <= 8'h20;
      for (i = 0; i < 3; i++) begin
         op(5'h12, ta[i], td[i]);
         op(5'h10, ta[i], 16'h0000);
         axr(`DPR_OFF_RDATA, {16'h0000, te[i]}, 32'h0000FFFF, 2'b00, "token", v);
      end
      $display("test tokens done");
      rt_mail <= 1'b1;
      @(posedge CLOCK);
      rt_mail <= 1'b0;
      axr(`DPR_OFF_STATUS, 32'h4, 32'h4, 2'b00, "mail_set", v);
      cont_req <= 1'b1;
      op(5'h0C, 16'hFFFE, 16'h0000);
      axr(`DPR_OFF_STATUS, 32'h6, 32'h6, 2'b00, "mail_kept", v);
      cont_req <= 1'b0;
      op(5'h0C, 16'hFFFE, 16'h0000);
      axr(`DPR_OFF_STATUS, 32'h0, 32'h4, 2'b00, "mail_clear", v);
      $display("test mailbox done");
      // Master's flag held low: the write must not reach the array
      cont_req <= 1'b1;
      op(5'h0E, a, ~e);
      axr(`DPR_OFF_STATUS, 32'h2, 32'h2, 2'b00, "cont_seen", v);
      cont_req <= 1'b0;
      op(5'h0C, a, 16'h0000);
      axr(`DPR_OFF_RDATA, {16'h0000, e}, 32'h0000FFFF, 2'b00, "blocked", v);
      $display("test slave block done");
      summarize();
   end
endmodule
